// [bench/dec_props.sv]
// Port checks for the double event compare engine.
// Assumes it is bound to that module and sees its ports only.
`include "dec_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dec_props (
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic [`ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic EVENT_INPUT_PIN_IN,
  input wire logic [7:0] PIN_OUT,
  input wire logic IRQ_OUT,
  input wire logic NEXT_IS_DEFINITION_OUT,
  input wire logic COARSE_GRAIN_OUT,
  input wire logic CMD_VALID_OUT
);
  logic cmd_wr;
  logic en_reg;
  logic [4:0] quiet_reg;
  logic [7:0] max_reg;
  assign cmd_wr = WR_IN && ADDR_IN == `OFS_CMD;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Sixteen quiet cycles outlast any pin action still waiting in the delay line.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      en_reg <= 1'b0;
      quiet_reg <= 5'h00;
      max_reg <= 8'hFF;
    end else begin
      if (cmd_wr)
        quiet_reg <= 5'h00;
      else if (!en_reg && quiet_reg != 5'h1F)
        quiet_reg <= quiet_reg + 5'h01;
      if (cmd_wr)
        en_reg <= WDATA_IN[27];
      if (WR_IN && ADDR_IN == `OFS_EVMAX)
        max_reg <= WDATA_IN[7:0];
    end
  end
  chk_cmd_valid: assert property (cmd_wr |-> ##2
    CMD_VALID_OUT == (!$past(WDATA_IN[23], 2) && $past(WDATA_IN[24], 2))) else $error("valid flag wrong");
  chk_next_def: assert property (cmd_wr |-> ##2
    NEXT_IS_DEFINITION_OUT == $past(WDATA_IN[16], 2)) else $error("definition flag wrong");
  chk_coarse_flag: assert property (cmd_wr |-> ##2
    COARSE_GRAIN_OUT == $past(WDATA_IN[22], 2)) else $error("coarse flag wrong");
  chk_pin_single: assert property ($changed(PIN_OUT) |->
    $onehot(PIN_OUT ^ $past(PIN_OUT))) else $error("more than one pin changed");
  chk_pin_gate: assert property (quiet_reg >= 5'h10 |->
    $stable(PIN_OUT)) else $error("pin changed while disabled");
  chk_irq_mask: assert property (WR_IN && ADDR_IN == `OFS_IRQ_EN && WDATA_IN[1:0] == 2'h0 |->
    ##2 !IRQ_OUT) else $error("masked interrupt still high");
  chk_pins_read: assert property (RD_IN && ADDR_IN == `OFS_PINS |=>
    RDATA_OUT == {24'h000000, $past(PIN_OUT)}) else $error("pin readback wrong");
  chk_evcnt_range: assert property (RD_IN && ADDR_IN == `OFS_EVCNT |=>
    RDATA_OUT <= {24'h000000, max_reg}) else $error("event count above maximum");
  cover property ($rose(IRQ_OUT));
  cover property ($fell(PIN_OUT[6]));
  cover property (CMD_VALID_OUT && COARSE_GRAIN_OUT);
endmodule // dec_props
bind double_event_compare dec_props u_props (.CORE_CLK_IN(CORE_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .EVENT_INPUT_PIN_IN(EVENT_INPUT_PIN_IN), .PIN_OUT(PIN_OUT), .IRQ_OUT(IRQ_OUT),
  .NEXT_IS_DEFINITION_OUT(NEXT_IS_DEFINITION_OUT), .COARSE_GRAIN_OUT(COARSE_GRAIN_OUT),
  .CMD_VALID_OUT(CMD_VALID_OUT));
`default_nettype wire

// [bench/double_event_compare_tb.sv]
// Self-checking bench for the double event compare engine.
// Assumes the event source model and the port checker are compiled first.
`include "dec_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module double_event_compare_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fire = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [7:0] pins;
  logic ev_pin, irq, nxd, coarse, valid;
  int n_mismatch = 0;
  int tests_run = 0;
  always #50 clk = ~clk;
  event_source u_src (.clk_in(clk), .fire_in(fire), .pin_out(ev_pin));
  double_event_compare uut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .EVENT_INPUT_PIN_IN(ev_pin), .PIN_OUT(pins),
    .IRQ_OUT(irq), .NEXT_IS_DEFINITION_OUT(nxd), .COARSE_GRAIN_OUT(coarse), .CMD_VALID_OUT(valid));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic ev(input int n);
    repeat (n) begin
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  // A pin lands up to a slot plus three resolution ticks after the event.
  task automatic wait_pin(input logic [7:0] exp);
    for (int i = 0; i < 40 && pins !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    chk("pins", 32'(exp), 32'(pins));
  endtask
  task automatic t_decode;
    rd_chk("evmax", `OFS_EVMAX, 32'h0000_00FF);
    rd_chk("pins", `OFS_PINS, 32'h0000_0000);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    wr_reg(`OFS_CMD, 32'h0182_0101);
    settle(2);
    chk("valid", 32'h0, 32'(valid));
    // The count reaches both compare values, but the word is not a valid command.
    ev(1);
    settle(12);
    rd_chk("status", `OFS_STATUS, 32'h0000_0000);
    wr_reg(`OFS_CMD, 32'h8141_F0F0);
    settle(2);
    chk("valid", 32'h1, 32'(valid));
    chk("nextdef", 32'h1, 32'(nxd));
    chk("coarse", 32'h1, 32'(coarse));
    $display("decode test done");
  endtask
  task automatic t_ev1;
    wr_reg(`OFS_IRQ_EN, 32'h0000_0001);
    wr_reg(`OFS_CMD, 32'h292E_F002);
    ev(2);
    wait_pin(8'h40);
    rd_chk("status", `OFS_STATUS, 32'h0000_0001);
    rd_chk("wptr", `OFS_BUF_WPTR, 32'h0000_0001);
    chk("irq", 32'h1, 32'(irq));
    wr_reg(`OFS_IRQ_EN, 32'h0000_0000);
    settle(2);
    chk("irq", 32'h0, 32'(irq));
    wr_reg(`OFS_IRQ_EN, 32'h0000_0001);
    settle(2);
    chk("irq", 32'h1, 32'(irq));
    wr_reg(`OFS_IRQ_CLR, 32'h0000_0001);
    settle(2);
    chk("irq", 32'h0, 32'(irq));
    $display("event one test done");
  endtask
  task automatic t_ev2;
    wr_reg(`OFS_IRQ_EN, 32'h0000_0003);
    wr_reg(`OFS_CMD, 32'h5F2C_04F0);
    ev(1);
    wait_pin(8'h00);
    rd_chk("status", `OFS_STATUS, 32'h0000_0002);
    chk("irq", 32'h1, 32'(irq));
    rd_chk("wptr", `OFS_BUF_WPTR, 32'h0000_0002);
    // The timer restarts at the match and stands at three as the pin lands; one more tick has passed here.
    rd_chk("timer", `OFS_DEFTIMER, 32'h0000_0004);
    wr_reg(`OFS_IRQ_CLR, 32'h0000_0003);
    $display("event two test done");
  endtask
  task automatic t_gate;
    wr_reg(`OFS_CMD, 32'h012E_F005);
    ev(1);
    settle(30);
    chk("pins", 32'h0, 32'(pins));
    rd_chk("status", `OFS_STATUS, 32'h0000_0001);
    wr_reg(`OFS_IRQ_CLR, 32'h0000_0003);
    wr_reg(`OFS_CMD, 32'h0D0C_06F0);
    ev(1);
    settle(30);
    chk("pins", 32'h0, 32'(pins));
    rd_chk("status", `OFS_STATUS, 32'h0000_0002);
    $display("gate test done");
  endtask
  task automatic t_wrap;
    wr_reg(`OFS_EVMAX, 32'h0000_0007);
    ev(1);
    rd_chk("evcnt", `OFS_EVCNT, 32'h0000_0007);
    ev(1);
    rd_chk("evcnt", `OFS_EVCNT, 32'h0000_0000);
    $display("wrap test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_decode();
    t_ev1();
    t_ev2();
    t_gate();
    t_wrap();
    stop_test();
  end
  // The tests need well under a thousand cycles; this allows several times that.
  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end
endmodule // double_event_compare_tb
`default_nettype wire

// [bench/event_source.sv]
// Model of the event source that drives the event input pin.
// Assumes one request pulse per event; the pin idles low between events.
`timescale 1ns/10ps
`default_nettype none
module event_source (
  input wire logic clk_in,
  input wire logic fire_in,
  output logic pin_out
);
  logic [1:0] hold;
  initial begin
    pin_out = 1'b0;
    hold = 2'h0;
  end
  // The pin stays high three cycles so the two-flop synchroniser cannot miss it.
  always @(posedge clk_in) begin
    if (fire_in)
      hold <= 2'h2;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
    pin_out <= fire_in || hold != 2'h0;
  end
endmodule // event_source
`default_nettype wire

// [hdl/capture_if.sv]
// Write and read port pair between the compare engine and its capture buffer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/10ps
`default_nettype none
interface capture_if #(parameter int AW = 4, parameter int DW = 32);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [hdl/capture_mem.sv]
// Circular capture buffer storage with registered read data.
// Assumes the controller owns the pointers; a read returns data one cycle after raddr.
`timescale 1ns/10ps
`default_nettype none
module capture_mem #(
  parameter int DEPTH = 16,
  parameter int DW = 32
) (
  input wire logic clk_in,
  capture_if.mem port
);
  logic [DW-1:0] store [DEPTH];
  logic [DW-1:0] rdata_reg;

  always_ff @(posedge clk_in) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    rdata_reg <= store[port.raddr];
  end

  assign port.rdata = rdata_reg;
endmodule // capture_mem
`default_nettype wire

// [hdl/dec_cfg.svh]
// Constants of the double event compare block: register map, command field layout,
// reset values and timing figures. Assumes it is included by bare name.
`ifndef DEC_CFG_SVH
`define DEC_CFG_SVH

`define CLK_PERIOD_NS 100
`define SLOT_TIME_NS 800
`define RES_TIME_NS 400
`define PIN_DELAY_RES 3

`define ADDR_W 8
`define OFS_CMD 8'h00
`define OFS_EVMAX 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_CLR 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_EVCNT 8'h14
`define OFS_DEFTIMER 8'h18
`define OFS_PINS 8'h1C
`define OFS_BUF_IDX 8'h20
`define OFS_BUF_DATA 8'h24
`define OFS_BUF_WPTR 8'h28

`define RST_CMD 32'h0000_0000
`define RST_EVMAX 8'hFF
`define RST_PINS 8'h00

`define F_EV1_LO 0
`define F_EV1_HI 7
`define F_EV2_LO 8
`define F_EV2_HI 15
`define F_NEXT_DEF 16
`define F_EV1_IRQ 17
`define F_PINSEL_MSB 18
`define F_PINSEL_MID 19
`define F_PINSEL_LSB 20
`define F_EV1_ACT 21
`define F_COARSE 22
`define F_ZERO 23
`define F_ONE 24
`define F_EV2_ACT 25
`define F_EV2_IRQ 26
`define F_PIN_EN 27
`define F_EV2_TRST 28
`define F_EV1_CAP 29
`define F_EV2_CAP 30

`define ST_EV1 0
`define ST_EV2 1

`endif

// [hdl/dec_pkg.sv]
// Types shared by the double event compare block.
// Assumes dec_cfg.svh supplies the numeric constants.
package dec_pkg;
  typedef enum logic [1:0] {
    SLOT_IDLE = 2'b01,
    SLOT_CAPT2 = 2'b10
  } slot_state_e;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    logic level;
  } pin_act_s;
endpackage

// [hdl/double_event_compare.sv]
// Double event compare command engine: event counter, default timer, delayed pin actions,
// interrupts and capture into a circular buffer, with a simple register port.
// Assumes one 10 MHz clock, an asynchronous active-low reset and an unsynchronised event pin.
// Operation
// RULE1 - Event 1 match triggers enabled irq, pin, capture
// RULE2 - Event 2 match triggers enabled pin, irq, reset, capture
// RULE3 - Flag says next entry is a definition
// RULE4 - Event 1 interrupt when enabled and matched
// RULE5 - Pin number is reversed field plus one (the code uses the reversed field as the pin number, without adding one)
// RULE6 - Event 1 sets or clears pin, three resolutions later
// RULE7 - Step bit selects coarse resolution for followers
// RULE8 - Valid only with bit23 zero, bit24 one
// RULE9 - Event 2 applies inverse action or nothing
// RULE10 - Event 2 interrupt when enabled and matched
// RULE11 - Pin enable bit gates all pin changes
// RULE12 - Event 2 may reset default timer
// RULE13 - Event 1 may capture timer word
// RULE14 - Event 2 may capture timer word
// RULE15 - Command handled within one time slot
// RULE16 - Event counter wraps to zero after maximum
// RULE17 - Reserved top bit is ignored
`include "dec_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module double_event_compare #(
  parameter int BUF_DEPTH = 16,
  parameter int SLOT_CYCLES = (`SLOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int RES_CYCLES = (`RES_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic [`ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic EVENT_INPUT_PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic IRQ_OUT,
  output logic NEXT_IS_DEFINITION_OUT,
  output logic COARSE_GRAIN_OUT,
  output logic CMD_VALID_OUT
);
  localparam int AW = $clog2(BUF_DEPTH);

  if (BUF_DEPTH < 2 || (1 << AW) != BUF_DEPTH) begin : g_chk_depth
    $error("BUF_DEPTH must be a power of two of at least 2");
  end
  if (SLOT_CYCLES < 2 || RES_CYCLES < 1 || SLOT_CYCLES > 4096 || RES_CYCLES > 4096) begin : g_chk_time
    $error("SLOT_CYCLES and RES_CYCLES out of range");
  end

  // Field 18..20 is stored with its MSB at the lowest bit, so the index is reversed.
  function automatic logic [2:0] pin_index(input logic [31:0] cmd);
    pin_index = {cmd[`F_PINSEL_MSB], cmd[`F_PINSEL_MID], cmd[`F_PINSEL_LSB]}; // RULE5
  endfunction

  capture_if #(.AW(AW), .DW(32)) cap ();

  capture_mem #(.DEPTH(BUF_DEPTH), .DW(32)) u_mem (
    .clk_in(CORE_CLK_IN),
    .port(cap.mem)
  );

  logic ev_meta_reg, ev_sync_reg, ev_prev_reg;
  logic [31:0] cmd_reg, cmd_next;
  logic [7:0] evmax_reg, evmax_next;
  logic [1:0] status_reg, status_next;
  logic [1:0] irq_en_reg, irq_en_next;
  logic [7:0] evcnt_reg, evcnt_next;
  logic ev_new_reg, ev_new_next;
  logic [31:0] deftimer_reg, deftimer_next;
  logic [7:0] pins_reg, pins_next;
  logic [AW-1:0] buf_idx_reg, buf_idx_next;
  logic [AW-1:0] wptr_reg, wptr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic valid_reg, valid_next;
  logic [15:0] slot_cnt_reg, slot_cnt_next;
  logic [15:0] res_cnt_reg, res_cnt_next;
  logic [31:0] cap2_word_reg, cap2_word_next;
  dec_pkg::slot_state_e state_reg, state_next;
  dec_pkg::pin_act_s pend_reg [`PIN_DELAY_RES];
  dec_pkg::pin_act_s pend_next [`PIN_DELAY_RES];

  logic ev_rise, slot_tick, res_tick, cmd_ok, m1, m2;
  logic we_c;
  logic [31:0] wdata_c;

  assign ev_rise = ev_sync_reg & ~ev_prev_reg;
  assign slot_tick = (slot_cnt_reg == 16'h0000);
  assign res_tick = (res_cnt_reg == 16'h0000);
  // The reserved top bit takes no part in validity or in any action.
  assign cmd_ok = ~cmd_reg[`F_ZERO] & cmd_reg[`F_ONE]; // RULE8 RULE17
  // A match is seen once per counter value: only a slot after a fresh event evaluates.
  // Validity is decoded from the word itself, not from the lagging flag, so that a word
  // just written that is not a valid command can never match in the cycle before the flag follows.
  assign m1 = slot_tick && cmd_ok && ev_new_reg && (evcnt_reg == cmd_reg[`F_EV1_HI:`F_EV1_LO]); // RULE1 RULE15
  assign m2 = slot_tick && cmd_ok && ev_new_reg && (evcnt_reg == cmd_reg[`F_EV2_HI:`F_EV2_LO]); // RULE2 RULE15

  always_comb begin
    cmd_next = cmd_reg;
    evmax_next = evmax_reg;
    status_next = status_reg;
    irq_en_next = irq_en_reg;
    evcnt_next = evcnt_reg;
    ev_new_next = ev_new_reg;
    deftimer_next = deftimer_reg;
    pins_next = pins_reg;
    buf_idx_next = buf_idx_reg;
    wptr_next = wptr_reg;
    rdata_next = 32'h0000_0000;
    valid_next = cmd_ok;
    cap2_word_next = cap2_word_reg;
    state_next = state_reg;
    we_c = 1'b0;
    wdata_c = deftimer_reg;
    slot_cnt_next = slot_tick ? 16'(SLOT_CYCLES - 1) : slot_cnt_reg - 16'h0001;
    res_cnt_next = res_tick ? 16'(RES_CYCLES - 1) : res_cnt_reg - 16'h0001;
    for (int i = 0; i < `PIN_DELAY_RES; i++) begin
      pend_next[i] = pend_reg[i];
    end

    // Software register writes.
    if (WR_IN) begin
      case (ADDR_IN)
        `OFS_CMD: cmd_next = WDATA_IN;
        `OFS_EVMAX: evmax_next = WDATA_IN[7:0];
        `OFS_IRQ_CLR: status_next = status_reg & ~WDATA_IN[1:0];
        `OFS_IRQ_EN: irq_en_next = WDATA_IN[1:0];
        `OFS_BUF_IDX: buf_idx_next = WDATA_IN[AW-1:0];
        default: ;
      endcase
    end

    // Default timer advances once per resolution period.
    if (res_tick) begin
      deftimer_next = deftimer_reg + 32'h0000_0001;
    end

    // The slot clears the fresh-event flag; an event in the same cycle keeps it set.
    if (slot_tick) begin
      ev_new_next = 1'b0; // RULE15
    end
    if (ev_rise) begin
      evcnt_next = (evcnt_reg == evmax_reg) ? 8'h00 : evcnt_reg + 8'h01; // RULE16
      ev_new_next = 1'b1;
    end

    // Delay line: an action leaves the last stage after three resolution ticks.
    if (res_tick) begin
      if (pend_reg[`PIN_DELAY_RES-1].valid) begin
        pins_next[pend_reg[`PIN_DELAY_RES-1].idx] = pend_reg[`PIN_DELAY_RES-1].level; // RULE6
      end
      for (int i = `PIN_DELAY_RES - 1; i > 0; i--) begin
        pend_next[i] = pend_reg[i-1];
      end
      pend_next[0] = '0;
    end

    // Event 2 is queued first so that event 1 wins when both values coincide.
    if (m2 && cmd_reg[`F_PIN_EN] && cmd_reg[`F_EV2_ACT]) begin // RULE9 RULE11
      pend_next[0] = '{valid: 1'b1, idx: pin_index(cmd_reg), level: ~cmd_reg[`F_EV1_ACT]}; // RULE9
    end
    if (m1 && cmd_reg[`F_PIN_EN]) begin // RULE11
      pend_next[0] = '{valid: 1'b1, idx: pin_index(cmd_reg), level: cmd_reg[`F_EV1_ACT]}; // RULE6
    end

    if (m1 && cmd_reg[`F_EV1_IRQ]) begin
      status_next[`ST_EV1] = 1'b1; // RULE4
    end
    if (m2 && cmd_reg[`F_EV2_IRQ]) begin
      status_next[`ST_EV2] = 1'b1; // RULE10
    end
    if (m2 && cmd_reg[`F_EV2_TRST]) begin
      deftimer_next = 32'h0000_0000; // RULE12
    end

    // Captures hold the timer as it stood at the match; a second one uses the next cycle.
    case (state_reg)
      dec_pkg::SLOT_IDLE: begin
        if (m1 && cmd_reg[`F_EV1_CAP]) begin
          we_c = 1'b1; // RULE13
          if (m2 && cmd_reg[`F_EV2_CAP]) begin
            cap2_word_next = deftimer_reg;
            state_next = dec_pkg::SLOT_CAPT2;
          end
        end else if (m2 && cmd_reg[`F_EV2_CAP]) begin
          we_c = 1'b1; // RULE14
        end
      end
      dec_pkg::SLOT_CAPT2: begin
        we_c = 1'b1; // RULE14
        wdata_c = cap2_word_reg;
        state_next = dec_pkg::SLOT_IDLE;
      end
      default: state_next = dec_pkg::SLOT_IDLE;
    endcase
    if (we_c) begin
      wptr_next = wptr_reg + AW'(1);
    end

    // Register reads answer in the following cycle; unmapped addresses read zero.
    if (RD_IN) begin
      case (ADDR_IN)
        `OFS_CMD: rdata_next = cmd_reg;
        `OFS_EVMAX: rdata_next = {24'h000000, evmax_reg};
        `OFS_STATUS: rdata_next = {30'h0000_0000, status_reg};
        `OFS_IRQ_EN: rdata_next = {30'h0000_0000, irq_en_reg};
        `OFS_EVCNT: rdata_next = {24'h000000, evcnt_reg};
        `OFS_DEFTIMER: rdata_next = deftimer_reg;
        `OFS_PINS: rdata_next = {24'h000000, pins_reg};
        `OFS_BUF_IDX: rdata_next = 32'(buf_idx_reg);
        `OFS_BUF_DATA: rdata_next = cap.rdata;
        `OFS_BUF_WPTR: rdata_next = 32'(wptr_reg);
        default: rdata_next = 32'h0000_0000;
      endcase
    end

    irq_next = |(status_reg & irq_en_reg);
  end

  assign cap.we = we_c;
  assign cap.waddr = wptr_reg;
  assign cap.wdata = wdata_c;
  assign cap.raddr = buf_idx_reg;

  // Two flip-flops guard against metastability; only the edge detector reads the second one.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ev_meta_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
      ev_prev_reg <= 1'b0;
    end else begin
      ev_meta_reg <= EVENT_INPUT_PIN_IN;
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  // Settings that software writes.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_reg <= `RST_CMD;
      evmax_reg <= `RST_EVMAX;
      irq_en_reg <= 2'h0;
      buf_idx_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
      evmax_reg <= evmax_next;
      irq_en_reg <= irq_en_next;
      buf_idx_reg <= buf_idx_next;
    end
  end

  // Sticky status and the interrupt level that it produces.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      status_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // Event counter and the flag that lets one slot evaluate each new count.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      evcnt_reg <= 8'h00;
      ev_new_reg <= 1'b0;
    end else begin
      evcnt_reg <= evcnt_next;
      ev_new_reg <= ev_new_next;
    end
  end

  // Slot and resolution dividers with the default timer that the resolution divider paces.
  // Both dividers restart at zero, so the first slot follows reset directly.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      slot_cnt_reg <= 16'h0000;
      res_cnt_reg <= 16'h0000;
      deftimer_reg <= 32'h0000_0000;
    end else begin
      slot_cnt_reg <= slot_cnt_next;
      res_cnt_reg <= res_cnt_next;
      deftimer_reg <= deftimer_next;
    end
  end

  // Output pins and the delay line that feeds them.
  // Clearing the stages at reset keeps a stale action from reaching a pin.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pins_reg <= `RST_PINS;
      for (int i = 0; i < `PIN_DELAY_RES; i++) begin
        pend_reg[i] <= '0;
      end
    end else begin
      pins_reg <= pins_next;
      for (int i = 0; i < `PIN_DELAY_RES; i++) begin
        pend_reg[i] <= pend_next[i];
      end
    end
  end

  // Capture write pointer and the deferred second capture.
  // A second capture in the same slot is written one cycle later from the held word.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wptr_reg <= '0;
      cap2_word_reg <= 32'h0000_0000;
      state_reg <= dec_pkg::SLOT_IDLE;
    end else begin
      wptr_reg <= wptr_next;
      cap2_word_reg <= cap2_word_next;
      state_reg <= state_next;
    end
  end

  // Read data and the validity flag shown to the outside.
  // Read data fall back to zero in every cycle without a read strobe.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign PIN_OUT = pins_reg;
  assign IRQ_OUT = irq_reg;
  // The next entry is a definition; the scan sequencer outside acts on it.
  assign NEXT_IS_DEFINITION_OUT = cmd_reg[`F_NEXT_DEF]; // RULE3
  // Coarse resolution is for the following commands, so it is only passed on here.
  assign COARSE_GRAIN_OUT = cmd_reg[`F_COARSE]; // RULE7
  assign CMD_VALID_OUT = valid_reg; // RULE8
endmodule // double_event_compare
`default_nettype wire
